//--- verilog/sgd_pkg.sv
// Constants shared by the serial gauge coil driver blocks.
// Assumes a single core clock domain; all pins are synchronised inside.
package sgd_pkg;
  // Angle word layout
  localparam int WORD_W = 10;
  localparam int OCT_W = 3;
  localparam int POS_W = 7;
  localparam int SEG_W = 5;
  localparam int FRAC_W = 3;
  // Coil magnitude code; full scale stands for 0.748 of analog_supply
  localparam int MAG_W = 8;
  localparam logic [7:0] MAG_FULL = 8'hff;
  localparam logic [7:0] MAG_ZERO = 8'h00;
  // Pin synchroniser
  localparam int PIN_W = 6;
  // APB register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_ANGLE = 8'h10;
  // Event bits of status and mask
  localparam int EV_W = 2;
  localparam int EV_FAULT = 0;
  localparam int EV_UPDATE = 1;
  // Control bit
  localparam int CTRL_FORCE_OFF = 0;
  // Values after reset
  localparam logic [9:0] ANGLE_RST = 10'h000;
  localparam logic [1:0] EV_RST = 2'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

//--- verilog/sgd_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes pins are unrelated levels; stage one feeds only stage two.
`timescale 1ns/1ps
module sgd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (clkEn) begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule

//--- verilog/sgd_tan_map.sv
// Tangential octant mapping from angle word to signed coil magnitudes.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module sgd_tan_map (
  // Angle word
  input wire logic [sgd_pkg::WORD_W-1:0] angle,
  // Coil magnitudes and signs
  output logic [sgd_pkg::MAG_W-1:0] sinMag,
  output logic [sgd_pkg::MAG_W-1:0] cosMag,
  output logic sinNeg,
  output logic cosNeg
);
  import sgd_pkg::*;

  // Tangent at every eighth position, full scale at 45 degrees
  function automatic logic [MAG_W-1:0] tanPoint(
    input logic [SEG_W-1:0] s
  );
    case (s)
      5'h00: tanPoint = 8'h00;
      5'h01: tanPoint = 8'h0d;
      5'h02: tanPoint = 8'h19;
      5'h03: tanPoint = 8'h26;
      5'h04: tanPoint = 8'h33;
      5'h05: tanPoint = 8'h40;
      5'h06: tanPoint = 8'h4d;
      5'h07: tanPoint = 8'h5b;
      5'h08: tanPoint = 8'h6a;
      5'h09: tanPoint = 8'h79;
      5'h0a: tanPoint = 8'h88;
      5'h0b: tanPoint = 8'h99;
      5'h0c: tanPoint = 8'haa;
      5'h0d: tanPoint = 8'hbd;
      5'h0e: tanPoint = 8'hd1;
      5'h0f: tanPoint = 8'he7;
      default: tanPoint = MAG_FULL;
    endcase
  endfunction

  logic [OCT_W-1:0] oct;
  logic [POS_W-1:0] pos;
  logic [SEG_W-1:0] seg;
  logic [FRAC_W-1:0] frac;
  logic [MAG_W-1:0] lo;
  logic [MAG_W-1:0] hi;
  logic [10:0] prod;
  logic [MAG_W-1:0] vary;
  logic cosVaries;

  assign oct = angle[WORD_W-1 -: OCT_W];
  // Odd octants run the tangent backwards
  assign pos = oct[0] ? ~angle[POS_W-1:0] : angle[POS_W-1:0];
  assign seg = {1'b0, pos[POS_W-1 -: 4]};
  assign frac = pos[FRAC_W-1:0];
  assign lo = tanPoint(seg);
  assign hi = tanPoint(seg + 5'h01);
  // Linear step between table points
  assign prod = 11'(hi - lo) * 11'(frac);
  assign vary = lo + prod[10:3];
  assign cosVaries = oct[0] ^ oct[1];
  assign sinMag = cosVaries ? MAG_FULL : vary;
  assign cosMag = cosVaries ? vary : MAG_FULL;
  assign sinNeg = oct[2];
  assign cosNeg = oct[2] ^ oct[1];
endmodule

//--- verilog/sgd_core.sv
// Serial gauge coil driver: serial link, angle latch, coil drive,
// fault shutdown, open-drain state flag and APB status registers.
// Assumes pins are asynchronous to core_clk; serial clock is slow.
//
// Functional notes
// - Serial data is captured on each rising serial clock edge while strobe is high.
// - Power-on reset clears all registers and latches except cosMag_reg and stOe_reg, which it sets.
// - Output-enable low switches all coil drivers off; logic runs on.
// - Serial data output changes only on falling serial clock edges.
// - Shifting happens only while the update strobe is high.
// - Falling strobe copies the shift register into the angle path.
// - Falling strobe re-enables drivers after fault unless fault persists.
// - State flag pulled low whenever the drivers are disabled.
// - Previously held ten-bit word shifts out as new one enters.
// - In each 45 degree span one coil varies, other sits at full scale.
// - First quadrant: sine tan then full, cosine full then tan.
// - Second quadrant: sine full then tan, cosine minus tan then minus full.
// - Third quadrant: sine minus tan then minus full, cosine minus.
// - Fourth quadrant: sine minus full then minus tan, cosine positive.
// - Top three bits pick the octant, low seven the position.
// - Shifting bits leave coil outputs unchanged until strobe falls.
`timescale 1ns/1ps
module sgd_core (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Serial link pins
  input wire logic sclkPin,
  input wire logic sdiPin,
  input wire logic strobePin,
  output logic sdoPin,
  // Drive control and fault detector pins
  input wire logic oePin,
  input wire logic overCurrentPin,
  input wire logic overTempPin,
  // Coil drive
  output logic [sgd_pkg::MAG_W-1:0] sinMag,
  output logic [sgd_pkg::MAG_W-1:0] cosMag,
  output logic sinNeg,
  output logic cosNeg,
  output logic drvOn,
  // Open-drain output_state_flag
  output logic outputStateFlagOut,
  output logic outputStateFlagOe,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sgd_pkg::ADDR_W-1:0] paddr,
  input wire logic [sgd_pkg::DATA_W-1:0] pwdata,
  output logic [sgd_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq
);
  import sgd_pkg::*;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == OFS_CTRL) || (a == OFS_STATUS) ||
      (a == OFS_MASK) || (a == OFS_STATE) || (a == OFS_ANGLE);
  endfunction

  // Pin synchronisation
  logic [PIN_W-1:0] pinSync;
  logic sclkS;
  logic sdiS;
  logic strobeS;
  logic oeS;
  logic ocS;
  logic otS;

  sgd_sync #(.W(PIN_W)) uSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .d({sclkPin, sdiPin, strobePin, oePin, overCurrentPin, overTempPin}),
    .q(pinSync)
  );

  assign {sclkS, sdiS, strobeS, oeS, ocS, otS} = pinSync;

  // Serial link state
  logic sclk_reg;
  logic sclk_next;
  logic strobe_reg;
  logic strobe_next;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic [WORD_W-1:0] angle_reg;
  logic [WORD_W-1:0] angle_next;
  logic sdo_reg;
  logic sdo_next;
  logic sclkRise;
  logic sclkFall;
  logic strobeFall;

  assign sclkRise = sclkS & ~sclk_reg;
  assign sclkFall = ~sclkS & sclk_reg;
  assign strobeFall = ~strobeS & strobe_reg;

  always_comb begin
    sclk_next = sclkS;
    strobe_next = strobeS;
    shift_next = shift_reg;
    sdo_next = sdo_reg;
    angle_next = angle_reg;
    if (sclkRise && strobeS) begin
      shift_next = {shift_reg[WORD_W-2:0], sdiS};
    end
    if (sclkFall) begin
      sdo_next = shift_reg[WORD_W-1];
    end
    if (strobeFall) begin
      angle_next = shift_reg;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_reg <= 1'b0;
      strobe_reg <= 1'b0;
      shift_reg <= ANGLE_RST;
      angle_reg <= ANGLE_RST;
      sdo_reg <= 1'b0;
    end else if (clkEn) begin
      sclk_reg <= sclk_next;
      strobe_reg <= strobe_next;
      shift_reg <= shift_next;
      angle_reg <= angle_next;
      sdo_reg <= sdo_next;
    end
  end

  // Coil drive state
  logic [MAG_W-1:0] mapSin;
  logic [MAG_W-1:0] mapCos;
  logic mapSinNeg;
  logic mapCosNeg;
  logic [MAG_W-1:0] sinMag_reg;
  logic [MAG_W-1:0] cosMag_reg;
  logic sinNeg_reg;
  logic cosNeg_reg;
  logic fault_reg;
  logic fault_next;
  logic arm_reg;
  logic arm_next;
  logic drvOn_reg;
  logic drvOn_next;
  logic stOe_reg;
  logic ctrl_reg;
  logic faultNow;

  sgd_tan_map uMap (
    .angle(angle_reg),
    .sinMag(mapSin),
    .cosMag(mapCos),
    .sinNeg(mapSinNeg),
    .cosNeg(mapCosNeg)
  );

  assign faultNow = ocS | otS;

  always_comb begin
    // Fault latch, cleared by the strobe only if the fault has gone
    fault_next = faultNow | (fault_reg & ~strobeFall);
    arm_next = arm_reg;
    if (faultNow) begin
      arm_next = 1'b0;
    end else if (strobeFall) begin
      arm_next = oeS;
    end
    drvOn_next = arm_next & oeS & ~ctrl_reg;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sinMag_reg <= MAG_ZERO;
      cosMag_reg <= MAG_FULL;
      sinNeg_reg <= 1'b0;
      cosNeg_reg <= 1'b0;
      fault_reg <= 1'b0;
      arm_reg <= 1'b0;
      drvOn_reg <= 1'b0;
      stOe_reg <= 1'b1;
    end else if (clkEn) begin
      sinMag_reg <= mapSin;
      cosMag_reg <= mapCos;
      sinNeg_reg <= mapSinNeg;
      cosNeg_reg <= mapCosNeg;
      fault_reg <= fault_next;
      arm_reg <= arm_next;
      drvOn_reg <= drvOn_next;
      stOe_reg <= ~drvOn_next;
    end
  end

  // APB registers and interrupt
  logic ctrl_next;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] status_next;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] mask_next;
  logic [EV_W-1:0] events;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic pready_reg;
  logic irq_reg;
  logic irq_next;
  logic wrAcc;
  logic setup;

  assign wrAcc = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign events = {strobeFall, faultNow & ~fault_reg};

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (wrAcc && paddr == OFS_CTRL) begin
      ctrl_next = pwdata[CTRL_FORCE_OFF];
    end
    if (wrAcc && paddr == OFS_MASK) begin
      mask_next = pwdata[EV_W-1:0];
    end
    if (wrAcc && paddr == OFS_STATUS) begin
      status_next = status_reg & ~pwdata[EV_W-1:0];
    end
    // A new event beats a clear in the same cycle
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
    if (setup) begin
      pslverr_next = ~isMapped(paddr);
      case (paddr)
        OFS_CTRL: prdata_next = 32'(ctrl_reg);
        OFS_STATUS: prdata_next = 32'(status_reg);
        OFS_MASK: prdata_next = 32'(mask_reg);
        OFS_STATE: prdata_next = 32'({fault_reg, otS, ocS, oeS,
          arm_reg, drvOn_reg});
        OFS_ANGLE: prdata_next = 32'(angle_reg);
        default: prdata_next = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= 1'b0;
      status_reg <= EV_RST;
      mask_reg <= EV_RST;
      prdata_reg <= RDATA_RST;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (clkEn) begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg <= 1'b1;
      irq_reg <= irq_next;
    end
  end

  // Outputs
  assign sdoPin = sdo_reg;
  assign sinMag = sinMag_reg;
  assign cosMag = cosMag_reg;
  assign sinNeg = sinNeg_reg;
  assign cosNeg = cosNeg_reg;
  assign drvOn = drvOn_reg;
  assign outputStateFlagOut = 1'b0;
  assign outputStateFlagOe = stOe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  // Checks
  logic [OCT_W-1:0] oct;
  assign oct = angle_reg[WORD_W-1 -: OCT_W];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n || !clkEn);

  sequence s_strobeFall;
    strobeFall && clkEn;
  endsequence

  sequence s_cleanRelease;
    s_strobeFall ##0 (oeS && !faultNow && !ctrl_reg);
  endsequence

  property p_shiftIn;
    sclkRise && strobeS |=> shift_reg[0] == $past(sdiS);
  endproperty
  a_shiftIn: assert property (p_shiftIn)
    else $error("serial bit not captured on rising clock");

  property p_shiftGate;
    sclkRise && !strobeS |=> $stable(shift_reg);
  endproperty
  a_shiftGate: assert property (p_shiftGate)
    else $error("shift while strobe low");

  property p_soFall;
    !sclkFall |=> $stable(sdo_reg);
  endproperty
  a_soFall: assert property (p_soFall)
    else $error("serial out changed off a falling edge");

  property p_soShift;
    sclkFall |=> sdo_reg == $past(shift_reg[WORD_W-1]);
  endproperty
  a_soShift: assert property (p_soShift)
    else $error("serial out not the held top bit");

  property p_latch;
    s_strobeFall |=> angle_reg == $past(shift_reg);
  endproperty
  a_latch: assert property (p_latch)
    else $error("angle not latched on strobe fall");

  property p_coilHold;
    !strobeFall ##1 !strobeFall |=> $stable(sinMag_reg) && $stable(cosMag_reg);
  endproperty
  a_coilHold: assert property (p_coilHold)
    else $error("coil drive moved without strobe");

  property p_oeOff;
    !oeS |=> !drvOn_reg && outputStateFlagOe;
  endproperty
  a_oeOff: assert property (p_oeOff)
    else $error("drivers on while output enable low");

  property p_faultOff;
    faultNow |=> !drvOn_reg [*2];
  endproperty
  a_faultOff: assert property (p_faultOff)
    else $error("drivers on during fault");

  property p_reenable;
    s_cleanRelease |=> drvOn_reg;
  endproperty
  a_reenable: assert property (p_reenable)
    else $error("drivers not re-enabled on strobe fall");

  property p_flag;
    stOe_reg == !drvOn_reg;
  endproperty
  a_flag: assert property (p_flag)
    else $error("state flag disagrees with drivers");

  property p_fullScale;
    (sinMag_reg == MAG_FULL) || (cosMag_reg == MAG_FULL);
  endproperty
  a_fullScale: assert property (p_fullScale)
    else $error("neither coil at full scale");

  property p_signs;
    1'b1 |=> sinNeg_reg == $past(oct[2]) &&
      cosNeg_reg == ($past(oct[2]) ^ $past(oct[1]));
  endproperty
  a_signs: assert property (p_signs)
    else $error("coil sign wrong for octant");

  property p_octStart;
    angle_reg[POS_W-1:0] == 7'h00 && !oct[0] && !oct[1]
      |=> sinMag_reg == MAG_ZERO;
  endproperty
  a_octStart: assert property (p_octStart)
    else $error("sine not zero at octant start");
endmodule

//--- sim/sgd_host_model.sv
// Host model: drives the serial link of the gauge driver core.
// Assumes core_clk is the bench clock; link half period is four cycles.
`timescale 1ns/1ps
module sgd_host_model (
  // Clock
  input wire logic core_clk,
  // Serial link
  output logic sclkPin,
  output logic sdiPin,
  output logic strobePin,
  input wire logic sdoPin
);
  localparam int HALF = 4;
  initial begin
    sclkPin = 1'b0;
    sdiPin = 1'b0;
    strobePin = 1'b0;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Word out, bits seen on sdo back; sclk idles low between frames
  task automatic frame(input logic [9:0] w, input logic sel,
                       input logic fall, output logic [9:0] seen,
                       output logic steady);
    steady = 1'b1;
    strobePin <= sel;
    waitc(HALF);
    for (int i = 9; i >= 0; i--) begin
      sdiPin <= w[i];
      waitc(HALF);
      sclkPin <= 1'b1;
      waitc(1);
      seen[i] = sdoPin;
      waitc(HALF - 1);
      if (sdoPin !== seen[i]) steady = 1'b0;
      sclkPin <= 1'b0;
    end
    waitc(HALF);
    if (fall) strobePin <= 1'b0;
    // Released line shows the inverse of its last value
    sdiPin <= ~w[0];
    waitc(HALF);
  endtask
  task automatic pulse();
    strobePin <= 1'b1;
    waitc(2 * HALF);
    strobePin <= 1'b0;
    waitc(HALF);
  endtask
endmodule

//--- sim/sgd_core_tb.sv
// Bench for the gauge driver core: host link model plus APB master.
// Assumes sgd_host_model drives the serial pins.
`timescale 1ns/1ps
module sgd_core_tb;
  import sgd_pkg::*;
  localparam int LIMIT = 20000;
  logic core_clk, arst_n, sclkPin, sdiPin, strobePin, sdoPin;
  logic oePin, overCurrentPin, overTempPin, drvOn, flagOut, flagOe;
  logic [MAG_W-1:0] sinMag, cosMag, a, b, c, d;
  logic sinNeg, cosNeg, psel, penable, pwrite, pready, pslverr, irq;
  logic perr, flagLine, st, clkEn;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [9:0] seen;
  int errCount, checksDone, cycles;
  assign flagLine = flagOe ? flagOut : 1'b1;
  sgd_core i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .sclkPin(sclkPin), .sdiPin(sdiPin), .strobePin(strobePin),
    .sdoPin(sdoPin), .oePin(oePin), .overCurrentPin(overCurrentPin),
    .overTempPin(overTempPin), .sinMag(sinMag), .cosMag(cosMag),
    .sinNeg(sinNeg), .cosNeg(cosNeg), .drvOn(drvOn),
    .outputStateFlagOut(flagOut), .outputStateFlagOe(flagOe),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq)
  );
  sgd_host_model i_host (
    .core_clk(core_clk), .sclkPin(sclkPin), .sdiPin(sdiPin),
    .strobePin(strobePin), .sdoPin(sdoPin)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errCount++;
      endSim();
    end
  end
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checksDone++;
    if (s !== e) begin
      errCount++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errCount++;
      endSim();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic send(input logic [9:0] w);
    i_host.frame(w, 1'b1, 1'b1, seen, st);
    tick(8);
  endtask
  task automatic tReset();
    chk("sinMag", sinMag, MAG_ZERO);
    chk("cosMag", cosMag, MAG_FULL);
    chk("drvOn", drvOn, 0);
    chk("flag", flagLine, 0);
    chk("pready", pready, 1);
    apb(1'b0, OFS_ANGLE, 0);
    chk("angle", rd, 0);
  endtask
  // Clock enable low freezes state, pins included
  task automatic tFreeze();
    clkEn <= 1'b0;
    overCurrentPin <= 1'b1;
    tick(6);
    chk("freeze", drvOn, 1);
    overCurrentPin <= 1'b0;
    tick(2);
    clkEn <= 1'b1;
    tick(6);
    chk("thaw", drvOn, 1);
  endtask
  task automatic tOctants();
    logic cf;
    for (int o = 0; o < 8; o++) begin
      send({o[2:0], 7'd64});
      cf = ~(o[0] ^ o[1]);
      chk("full", cf ? cosMag : sinMag, MAG_FULL);
      chk("vary", (cf ? sinMag : cosMag) == MAG_FULL, 0);
      chk("sinNeg", sinNeg, o[2]);
      chk("cosNeg", cosNeg, o[1] ^ o[2]);
      chk("drvOn", drvOn, 1);
      chk("flag", flagLine, 1);
      apb(1'b0, OFS_ANGLE, 0);
      chk("angle", rd, {o[2:0], 7'd64});
    end
    apb(1'b0, OFS_STATUS, 0);
    chk("update", rd[EV_UPDATE], 1);
    apb(1'b1, OFS_STATUS, 32'h0000_0002);
  endtask
  task automatic tMirror();
    send(10'h020);
    a = sinMag;
    send(10'h060);
    b = sinMag;
    send(10'h0a0);
    c = cosMag;
    send(10'h0e0);
    d = cosMag;
    chk("rise", b > a, 1);
    chk("mirror", c > d, 1);
  endtask
  task automatic tDaisy();
    send(10'h2a5);
    send(10'h15a);
    chk("sdo", seen, 10'h2a5);
    chk("sdoEdge", st, 1);
    a = sinMag;
    i_host.frame(10'h0ab, 1'b1, 1'b0, seen, st);
    tick(8);
    chk("hold", sinMag, a);
    apb(1'b0, OFS_ANGLE, 0);
    chk("hold", rd, 10'h15a);
    i_host.pulse();
    tick(8);
    apb(1'b0, OFS_ANGLE, 0);
    chk("latch", rd, 10'h0ab);
    i_host.frame(10'h3ff, 1'b0, 1'b1, seen, st);
    i_host.pulse();
    tick(8);
    apb(1'b0, OFS_ANGLE, 0);
    chk("noShift", rd, 10'h0ab);
  endtask
  task automatic tOe();
    oePin <= 1'b0;
    tick(6);
    chk("drvOn", drvOn, 0);
    chk("flag", flagLine, 0);
    oePin <= 1'b1;
    tick(6);
    chk("drvOn", drvOn, 1);
    oePin <= 1'b0;
    send(10'h100);
    apb(1'b0, OFS_ANGLE, 0);
    chk("angle", rd, 10'h100);
    oePin <= 1'b1;
    i_host.pulse();
    tick(8);
  endtask
  task automatic tFault();
    apb(1'b1, OFS_MASK, 32'h0000_0001);
    overCurrentPin <= 1'b1;
    tick(6);
    chk("drvOn", drvOn, 0);
    chk("flag", flagLine, 0);
    chk("irq", irq, 1);
    overCurrentPin <= 1'b0;
    tick(6);
    chk("latched", drvOn, 0);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    tick(2);
    chk("irqClr", irq, 0);
    overTempPin <= 1'b1;
    i_host.pulse();
    tick(6);
    chk("persist", drvOn, 0);
    overTempPin <= 1'b0;
    apb(1'b1, OFS_MASK, 0);
    tick(2);
    chk("masked", irq, 0);
    i_host.pulse();
    tick(6);
    chk("rearm", drvOn, 1);
    chk("flag", flagLine, 1);
    apb(1'b1, OFS_STATUS, 32'h0000_0003);
  endtask
  task automatic tApb();
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    tick(3);
    chk("forceOff", drvOn, 0);
    chk("flag", flagLine, 0);
    apb(1'b1, OFS_CTRL, 0);
    tick(3);
    chk("forceOn", drvOn, 1);
    apb(1'b0, 8'h20, 0);
    chk("slverr", perr, 1);
    chk("rdZero", rd, 0);
  endtask
  initial begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    oePin = 1'b1;
    overCurrentPin = 1'b0;
    overTempPin = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errCount = 0;
    checksDone = 0;
    cycles = 0;
    tick(12);
    arst_n <= 1'b1;
    tick(3);
    tReset();
    tOctants();
    tMirror();
    tDaisy();
    tOe();
    tFault();
    tApb();
    tFreeze();
    endSim();
  end
endmodule
